// *** verification/link_loss_supervisor_tb.sv ***
`timescale 1ns/1ps
module link_loss_supervisor_tb;
    import link_loss_pkg::*;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0000_0000;
    logic              wrStb = 1'b0;
    logic              rdStb = 1'b0;
    logic              cut1 = 1'b0;
    logic              cut2 = 1'b0;
    logic              driveRunning = 1'b0;
    logic              cyclicActive = 1'b0;
    logic [DATA_W-1:0] rdata, gatewayAddr, d;
    logic [SET_W-1:0]  tripStopMode;
    logic              up1, up2, warn, alarm, trip, snmp, dupIp, relay, irq;
    int                errorCnt = 0;
    int                nChecks = 0;
    int                cycles = 0;

    // ==========================================================
    // Clock, partner ports and design
    // ==========================================================
    always #20 clk = ~clk;
    phy_port_model first_port (.cableCut(cut1), .linkUp(up1));
    phy_port_model second_port (.cableCut(cut2), .linkUp(up2));
    link_loss_supervisor dut (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
        .firstPortLinkUp(up1), .secondPortLinkUp(up2),
        .driveRunning(driveRunning), .cyclicActive(cyclicActive),
        .linkLossWarning(warn), .alarmOutput(alarm), .linkLossTrip(trip),
        .tripStopMode(tripStopMode), .snmpEnable(snmp),
        .dupIpDetect(dupIp), .relayAtReset(relay),
        .gatewayAddr(gatewayAddr), .irq(irq));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Counts one comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] e, g);
        nChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Compares the three reaction outputs at once.
    task automatic chkOut(input logic w, a, t);
        chk("warning", {31'h0, w}, {31'h0, warn});
        chk("alarm", {31'h0, a}, {31'h0, alarm});
        chk("trip", {31'h0, t}, {31'h0, trip});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask

    // Read data is taken in the cycle after the strobe only.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 v = rdata;
    endtask

    // Sets both cables and waits out the synchroniser.
    task automatic setLinks(input logic c1, c2);
        @(posedge clk);
        cut1 <= c1;
        cut2 <= c2;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Writes both actions and applies them as a device reset.
    task automatic applyCfg(input logic [15:0] f, s);
        wr(OFS_FIRST, {16'h0000, f});
        wr(OFS_SECOND, {16'h0000, s});
        wr(OFS_APPLY, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic testDefaults();
        rd(OFS_SECOND, d);
        chk("second default", {16'h0000, ACT_EITHER}, d);
        rd(8'h3c, d);
        chk("unmapped read", 32'h0000_0000, d);
        chk("snmp", 32'h0000_0001, {31'h0, snmp});
        chk("dup ip", 32'h0000_0001, {31'h0, dupIp});
        $display("test defaults done");
    endtask

    task automatic testEither();
        @(posedge clk);
        driveRunning <= 1'b1;
        setLinks(1'b0, 1'b1);
        chkOut(1'b0, 1'b0, 1'b1);
        setLinks(1'b0, 1'b0);
        wr(OFS_APPLY, 32'h0000_0001);
        driveRunning <= 1'b0;
        setLinks(1'b1, 1'b0);
        chkOut(1'b0, 1'b0, 1'b0);
        setLinks(1'b0, 1'b0);
        @(posedge clk);
        driveRunning <= 1'b1;
        $display("test either done");
    endtask

    task automatic testPerPort();
        for (int k = 0; k < 4; k++) begin
            applyCfg(ACT_ALARM, 16'(k));
            setLinks(1'b0, 1'b1);
            chkOut(k == 1 || k == 2, k == 2, k == 3);
            setLinks(1'b1, 1'b0);
            chkOut(1'b1, 1'b1, k == 3);
            setLinks(1'b0, 1'b0);
        end
        $display("test per port done");
    endtask

    task automatic testBothAndIrq();
        applyCfg(ACT_WARN, ACT_BOTH);
        wr(OFS_MASK, 32'h0000_0001);
        rd(OFS_STATUS, d);
        setLinks(1'b1, 1'b0);
        chkOut(1'b0, 1'b0, 1'b0);
        setLinks(1'b1, 1'b1);
        chkOut(1'b1, 1'b0, 1'b0);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rd(OFS_STATUS, d);
        chk("status", 32'h0000_0001, d);
        @(posedge clk);
        #1 chk("irq after read", 32'h0000_0000, {31'h0, irq});
        setLinks(1'b0, 1'b0);
        $display("test both done");
    endtask

    task automatic testCyclic();
        applyCfg(ACT_OFF, ACT_OFF);
        @(posedge clk);
        cyclicActive <= 1'b1;
        setLinks(1'b0, 1'b1);
        chkOut(1'b0, 1'b0, 1'b1);
        setLinks(1'b0, 1'b0);
        @(posedge clk);
        cyclicActive <= 1'b0;
        wr(OFS_APPLY, 32'h0000_0001);
        $display("test cyclic done");
    endtask

    task automatic testSettings();
        wr(OFS_SLOT2, {16'h0000, SLOT_NOSNMP});
        wr(OFS_RELAY, {16'h0000, RELAY_ON});
        wr(OFS_STOP, 32'h0000_0002);
        wr(OFS_GATE, 32'hc0a8_0001);
        wr(OFS_DIAG, 32'h0000_0001);
        #1 chk("snmp pending", 32'h0000_0001, {31'h0, snmp});
        wr(OFS_RELAY, 32'h0000_0005);
        rd(OFS_RELAY, d);
        chk("relay refused", {16'h0000, RELAY_ON}, d);
        wr(OFS_APPLY, 32'h0000_0001);
        @(posedge clk);
        #1 chk("snmp", 32'h0000_0000, {31'h0, snmp});
        chk("relay", 32'h0000_0001, {31'h0, relay});
        chk("stop mode", 32'h0000_0002, {16'h0000, tripStopMode});
        chk("gateway", 32'hc0a8_0001, gatewayAddr);
        chk("dup ip", 32'h0000_0000, {31'h0, dupIp});
        $display("test settings done");
    endtask

    // ==========================================================
    // Sequence, watchdog and verdict
    // ==========================================================
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            finalReport();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        testDefaults();
        testEither();
        testPerPort();
        testBothAndIrq();
        testCyclic();
        testSettings();
        finalReport();
    end
endmodule

// *** verification/phy_port_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Physical port model
// ==========================================================
module phy_port_model (
    input  wire logic cableCut,
    output wire logic linkUp
);
    // level link status
    // Link status follows the cable with a skew unrelated to the clock.
    assign #7 linkUp = ~cableCut;
endmodule

// *** verilog/link_loss_pkg.sv ***
package link_loss_pkg;

    // ==========================================================
    // Bus and field widths
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SET_W  = 16;
    localparam int SLOTS  = 4;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] OFS_FIRST  = 8'h00;
    localparam logic [7:0] OFS_SECOND = 8'h04;
    localparam logic [7:0] OFS_STOP   = 8'h08;
    localparam logic [7:0] OFS_DIAG   = 8'h0c;
    localparam logic [7:0] OFS_RELAY  = 8'h10;
    localparam logic [7:0] OFS_SLOT0  = 8'h14;
    localparam logic [7:0] OFS_SLOT1  = 8'h18;
    localparam logic [7:0] OFS_SLOT2  = 8'h1c;
    localparam logic [7:0] OFS_SLOT3  = 8'h20;
    localparam logic [7:0] OFS_GATE   = 8'h24;
    localparam logic [7:0] OFS_APPLY  = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_MASK   = 8'h30;
    localparam logic [7:0] OFS_STATE  = 8'h34;

    // ==========================================================
    // Setting codes
    // ==========================================================
    localparam logic [15:0] ACT_OFF    = 16'h0000;
    localparam logic [15:0] ACT_WARN   = 16'h0001;
    localparam logic [15:0] ACT_ALARM  = 16'h0002;
    localparam logic [15:0] ACT_TRIP   = 16'h0003;
    localparam logic [15:0] ACT_BOTH   = 16'h22b8;
    localparam logic [15:0] ACT_EITHER = 16'h270f;
    localparam logic [15:0] DIAG_SNMP  = 16'h0001;
    localparam logic [15:0] DIAG_DUPIP = 16'h0002;
    localparam logic [15:0] DIAG_ALL   = 16'h270f;
    localparam logic [15:0] RELAY_OFF  = 16'h0000;
    localparam logic [15:0] RELAY_ON   = 16'h270f;
    localparam logic [15:0] SLOT_NOSNMP = 16'h8892;

    // ==========================================================
    // Status, mask and state bit positions
    // ==========================================================
    localparam int ST_W     = 3;
    localparam int ST_WARN  = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_TRIP  = 2;
    localparam int SB_LOSS0 = 3;
    localparam int SB_LOSS1 = 4;
    localparam int SB_SNMP  = 5;
    localparam int APPLY_BIT = 0;

    // Reaction of one port evaluation.
    typedef struct packed {
        logic warn;
        logic alarm;
        logic trip;
    } reaction_t;

    // Communication settings, held as pending and as active copy.
    typedef struct packed {
        logic [SET_W-1:0]            first;
        logic [SET_W-1:0]            second;
        logic [SET_W-1:0]            stopMode;
        logic [SET_W-1:0]            netDiag;
        logic [SET_W-1:0]            relay;
        logic [SLOTS-1:0][SET_W-1:0] slots;
        logic [DATA_W-1:0]           gateway;
    } settings_t;

    // Values taken at reset and power-on.
    localparam settings_t SET_DEFAULT = '{
        first:    16'h0003,
        second:   16'h270f,
        stopMode: 16'h0000,
        netDiag:  16'h270f,
        relay:    16'h0000,
        slots:    {16'h270f, 16'hb0b6, 16'hb0b5, 16'h1389},
        gateway:  32'h0000_0000
    };

endpackage

// *** verilog/link_loss_supervisor.sv ***
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - second action 0 ignores second port
// - second action 1 gives warning only
// - second action 2 adds alarm output
// - second action 3 trips instead
// - 8888 applies first action on both lost
// - 9999 applies first action on either lost
// - actions 0 to 3 act per port
// - cyclic traffic loss trips whatever the actions, while drive running
// - no trip while drive stopped
// - trip follows configured stop mode
// - settings apply only after reset
// - slot 34962 disables SNMP
// - relay-at-reset accepts only 0 or 9999
// - gateway address routes off-network traffic
module link_loss_supervisor
    import link_loss_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wrStb,
    input  wire logic              rdStb,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              firstPortLinkUp,
    input  wire logic              secondPortLinkUp,
    input  wire logic              driveRunning,
    input  wire logic              cyclicActive,
    output logic                   linkLossWarning,
    output logic                   alarmOutput,
    output logic                   linkLossTrip,
    output logic      [SET_W-1:0]  tripStopMode,
    output logic                   snmpEnable,
    output logic                   dupIpDetect,
    output logic                   relayAtReset,
    output logic      [DATA_W-1:0] gatewayAddr,
    output logic                   irq
);

    // ==========================================================
    // Declarations
    // ==========================================================
    settings_t         pend;
    settings_t         act;
    logic [1:0]        linkPins;
    logic [1:0]        linkLvl;
    logic [1:0]        lossLvl;
    logic              lossA;
    logic [SET_W-1:0]  actionB;
    reaction_t         reactA;
    reaction_t         reactB;
    logic              next_warn;
    logic              next_alarm;
    logic              tripReq;
    logic              next_trip;
    logic              applyNow;
    logic              slotHit;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic [ST_W-1:0]   events;
    logic [ST_W-1:0]   next_status;
    logic [DATA_W-1:0] next_rdata;
    logic              statusRead;
    logic [SET_W-1:0]  wset;

    assign wset       = wdata[SET_W-1:0];
    assign applyNow   = wrStb && (addr == OFS_APPLY) && wdata[APPLY_BIT];
    assign statusRead = rdStb && (addr == OFS_STATUS);

    // ==========================================================
    // Link status inputs
    // ==========================================================
    // Pins from the physical layers come in asynchronously.
    assign linkPins = {secondPortLinkUp, firstPortLinkUp};

    for (genvar p = 0; p < 2; p++) begin : gSync
        sync_filter uSync (
            .clk   (clk),
            .reset (reset),
            .pin   (linkPins[p]),
            .level (linkLvl[p])
        );
    end

    // A port without link counts as signal loss.
    assign lossLvl = ~linkLvl;

    // ==========================================================
    // Reaction selection
    // ==========================================================
    // first-action loss: both ports lost, either port lost, or first port alone
    always_comb begin
        unique case (act.second)
            ACT_BOTH:   lossA = lossLvl[0] & lossLvl[1];
            ACT_EITHER: lossA = lossLvl[0] | lossLvl[1];
            default:    lossA = lossLvl[0];
        endcase
    end

    always_comb begin
        if ((act.second == ACT_BOTH) || (act.second == ACT_EITHER)) begin
            actionB = ACT_OFF;
        end else begin
            actionB = act.second;
        end
    end

    loss_reaction uReactA (
        .action (act.first),
        .loss   (lossA),
        .react  (reactA)
    );

    loss_reaction uReactB (
        .action (actionB),
        .loss   (lossLvl[1]),
        .react  (reactB)
    );

    assign next_warn  = reactA.warn | reactB.warn;
    assign next_alarm = reactA.alarm | reactB.alarm;

    assign tripReq = reactA.trip | reactB.trip
                   | (cyclicActive & (lossLvl[0] | lossLvl[1]));

    always_comb begin
        next_trip = linkLossTrip;
        if (applyNow) begin
            next_trip = 1'b0;
        end
        if (tripReq && driveRunning) begin
            next_trip = 1'b1;
        end
    end

    // ==========================================================
    // Indication outputs
    // ==========================================================
    // Warning and alarm follow the loss level every cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            linkLossWarning <= 1'b0;
            alarmOutput     <= 1'b0;
        end else begin
            linkLossWarning <= next_warn;
            alarmOutput     <= next_alarm;
        end
    end

    // The trip latches until a device reset; a new request wins.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            linkLossTrip <= 1'b0;
        end else begin
            linkLossTrip <= next_trip;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tripStopMode <= SET_DEFAULT.stopMode;
        end else begin
            tripStopMode <= act.stopMode;
        end
    end

    // ==========================================================
    // Network service outputs
    // ==========================================================
    // SNMP slot check
    always_comb begin
        slotHit = 1'b0;
        for (int s = 0; s < SLOTS; s++) begin
            if (act.slots[s] == SLOT_NOSNMP) begin
                slotHit = 1'b1;
            end
        end
    end

    // Diagnosis services, relay mode and gateway from active settings.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            snmpEnable   <= 1'b0;
            dupIpDetect  <= 1'b0;
            relayAtReset <= 1'b0;
            gatewayAddr  <= '0;
        end else begin
            snmpEnable   <= !slotHit && ((act.netDiag == DIAG_SNMP)
                            || (act.netDiag == DIAG_ALL));
            dupIpDetect  <= (act.netDiag == DIAG_DUPIP)
                            || (act.netDiag == DIAG_ALL);
            relayAtReset <= (act.relay == RELAY_ON);
            gatewayAddr  <= act.gateway;
        end
    end

    // ==========================================================
    // Settings registers
    // ==========================================================
    // Writes land in the pending copy; out-of-range codes are dropped.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend <= SET_DEFAULT;
        end else if (wrStb) begin
            unique case (addr)
                OFS_FIRST: begin
                    if (wset <= ACT_TRIP) begin
                        pend.first <= wset;
                    end
                end
                OFS_SECOND: begin
                    if ((wset <= ACT_TRIP) || (wset == ACT_BOTH)
                        || (wset == ACT_EITHER)) begin
                        pend.second <= wset;
                    end
                end
                OFS_STOP:  pend.stopMode <= wset;
                OFS_DIAG: begin
                    if ((wset <= DIAG_DUPIP) || (wset == DIAG_ALL)) begin
                        pend.netDiag <= wset;
                    end
                end
                OFS_RELAY: begin
                    if ((wset == RELAY_OFF) || (wset == RELAY_ON)) begin
                        pend.relay <= wset;
                    end
                end
                OFS_SLOT0: pend.slots[0] <= wset;
                OFS_SLOT1: pend.slots[1] <= wset;
                OFS_SLOT2: pend.slots[2] <= wset;
                OFS_SLOT3: pend.slots[3] <= wset;
                OFS_GATE:  pend.gateway  <= wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act <= SET_DEFAULT;
        end else if (applyNow) begin
            act <= pend;
        end
    end

    // ==========================================================
    // Interrupt status and mask
    // ==========================================================
    // Rising edges of the three indications are the events.
    assign events = {next_trip & ~linkLossTrip,
                     next_alarm & ~alarmOutput,
                     next_warn & ~linkLossWarning};

    // A read clears the status, but a same-cycle event still sets.
    always_comb begin
        next_status = status;
        if (statusRead) begin
            next_status = '0;
        end
        next_status = next_status | events;
    end

    // Sticky status bits.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // Mask register, same layout as status.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask <= '0;
        end else if (wrStb && (addr == OFS_MASK)) begin
            mask <= wdata[ST_W-1:0];
        end
    end

    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & mask);
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    // Read mux; unmapped offsets read as zero.
    always_comb begin
        next_rdata = '0;
        unique case (addr)
            OFS_FIRST:  next_rdata[SET_W-1:0] = pend.first;
            OFS_SECOND: next_rdata[SET_W-1:0] = pend.second;
            OFS_STOP:   next_rdata[SET_W-1:0] = pend.stopMode;
            OFS_DIAG:   next_rdata[SET_W-1:0] = pend.netDiag;
            OFS_RELAY:  next_rdata[SET_W-1:0] = pend.relay;
            OFS_SLOT0:  next_rdata[SET_W-1:0] = pend.slots[0];
            OFS_SLOT1:  next_rdata[SET_W-1:0] = pend.slots[1];
            OFS_SLOT2:  next_rdata[SET_W-1:0] = pend.slots[2];
            OFS_SLOT3:  next_rdata[SET_W-1:0] = pend.slots[3];
            OFS_GATE:   next_rdata = pend.gateway;
            OFS_STATUS: next_rdata[ST_W-1:0] = status;
            OFS_MASK:   next_rdata[ST_W-1:0] = mask;
            OFS_STATE: begin
                next_rdata[ST_WARN]  = linkLossWarning;
                next_rdata[ST_ALARM] = alarmOutput;
                next_rdata[ST_TRIP]  = linkLossTrip;
                next_rdata[SB_LOSS0] = lossLvl[0];
                next_rdata[SB_LOSS1] = lossLvl[1];
                next_rdata[SB_SNMP]  = snmpEnable;
            end
            default: next_rdata = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= '0;
        end else if (rdStb) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_SECOND_OFF: assert property (
        (act.second == ACT_OFF) && !lossLvl[0]
        |=> !linkLossWarning && !alarmOutput)
        else $error("second port loss reacted while disabled");

    AST_SECOND_WARN: assert property (
        (act.second == ACT_WARN) && lossLvl[1] && !lossLvl[0]
        |=> linkLossWarning && !alarmOutput)
        else $error("warning-only setting gave wrong outputs");

    AST_SECOND_ALARM: assert property (
        (act.second == ACT_ALARM) && lossLvl[1]
        |=> linkLossWarning && alarmOutput)
        else $error("alarm setting did not raise warning and alarm");

    AST_SECOND_TRIP: assert property (
        (act.second == ACT_TRIP) && lossLvl[1] && driveRunning
        |=> linkLossTrip)
        else $error("trip setting did not trip");

    AST_BOTH_LOST: assert property (
        (act.second == ACT_BOTH) && (act.first == ACT_WARN)
        && (lossLvl != 2'b11) |=> !linkLossWarning)
        else $error("both-port mode reacted on a single loss");

    AST_EITHER_LOST: assert property (
        (act.second == ACT_EITHER) && (act.first == ACT_TRIP)
        && (lossLvl != 2'b00) && driveRunning |=> linkLossTrip)
        else $error("either-port mode missed a loss");

    AST_PER_PORT: assert property (
        (act.first == ACT_ALARM) && (act.second <= ACT_TRIP)
        && (lossLvl == 2'b01) |=> linkLossWarning && alarmOutput)
        else $error("first port action not applied alone");

    AST_CYCLIC_TRIP: assert property (
        cyclicActive && (lossLvl != 2'b00) && driveRunning
        |=> linkLossTrip)
        else $error("loss during cyclic traffic did not trip");

    AST_STOP_EXEMPT: assert property (
        !driveRunning && !linkLossTrip |=> !linkLossTrip)
        else $error("trip raised while drive stopped");

    AST_STOP_MODE: assert property (
        linkLossTrip && $stable(act.stopMode)
        |-> tripStopMode == act.stopMode)
        else $error("trip stop mode differs from setting");

    AST_APPLY_ONLY: assert property (
        !applyNow |=> $stable(act))
        else $error("active settings changed without reset");

    AST_SNMP_OFF: assert property (
        slotHit |=> !snmpEnable)
        else $error("SNMP enabled with blocking slot value");

    AST_RELAY_RANGE: assert property (
        wrStb && (addr == OFS_RELAY) && (wset != RELAY_OFF)
        && (wset != RELAY_ON) |=> $stable(pend.relay))
        else $error("relay selection took an illegal value");

    AST_LOSS_LEVEL: assert property (
        $changed(lossLvl) && (act.first == ACT_ALARM)
        && (act.second == ACT_ALARM) |=> alarmOutput == |$past(lossLvl))
        else $error("alarm did not follow link level change");

endmodule

// *** verilog/loss_reaction.sv ***
`timescale 1ns/1ps
module loss_reaction
    import link_loss_pkg::*;
(
    input  wire logic [SET_W-1:0] action,
    input  wire logic             loss,
    output reaction_t             react
);

    // Decodes one action code against one loss level.
    always_comb begin
        react = '0;
        case (action)
            ACT_WARN: begin
                react.warn = loss;
            end
            ACT_ALARM: begin
                react.warn  = loss;
                react.alarm = loss;
            end
            ACT_TRIP: begin
                react.trip = loss;
            end
            default: begin
                react = '0;
            end
        endcase
    end

endmodule

// *** verilog/sync_filter.sv ***
`timescale 1ns/1ps
module sync_filter
    import link_loss_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Three stages and an output flop; the output moves once stages two and three agree.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule
